// *** rtl/nvm_consts.vh ***
// Constants for the nonvolatile data and program memory access block
// Function
// - space_select picks data or program memory
// - Data memory: 64 bytes, low index only
// - Program memory: 2K words, one word each
// - High and low data form 14-bit word
// - Program location is 13 bits from both indexes
// - Unused upper data bits read as zero
// - Data read result ready next cycle
// - Program read result ready after two cycles
// - fetch_go set-only, cleared by hardware when done
// - No write cycle while modify_permit is clear
// - cycle_launch set-only, cleared by hardware when done
// - Data write: erase, program, core runs, flag
// - Program write stalls core, erase, program, flag
// - Events held pending; one instruction before vector
// - Pin or watchdog reset mid-write sets abort_flag
// - Soft resets keep data, index, space_select
// - space_select writes ignored while access busy
// - Low data holds result until read or write
// - unlock_port stores nothing, only detects sequence
// - No bulk erase reachable from software
// - 55h, AAh, then launch, consecutively, else rejected
// - Launch needs modify_permit set beforehand
// - Clearing modify_permit never aborts a write
// - Two setup slots before program write stalls
`ifndef NVM_CONSTS_VH
`define NVM_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define NVM_CTL_OFS        12'h18C
`define NVM_KEY_OFS        12'h190
`define NVM_LO_OFS         12'h194
`define NVM_HI_OFS         12'h198
`define NVM_IL_OFS         12'h19C
`define NVM_IH_OFS         12'h1A0
`define NVM_ST_OFS         12'h1A4

// ----------------------------------------------------------------
// Control field positions and keys
// ----------------------------------------------------------------
`define NVM_RD_BIT         0
`define NVM_WR_BIT         1
`define NVM_MODIFY_PERMIT_BIT       2
`define NVM_ERR_BIT        3
`define NVM_SPACE_BIT      7
`define NVM_DONE_BIT       0
`define NVM_KEY_FIRST      8'h55
`define NVM_KEY_SECOND     8'hAA

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define NVM_CTL_RST        1'b0
`define NVM_CLK_NS         10
`define NVM_ERASE_NS       4000
`define NVM_PROG_NS        4000
`define NVM_ERASE_CYC      ((`NVM_ERASE_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
`define NVM_PROG_CYC       ((`NVM_PROG_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
`define NVM_SETUP_SLOTS    2
`define NVM_FLASH_RD_SLOTS 2

`endif

// *** rtl/nvm_store.v ***
// Storage arrays for data memory bytes and program memory words
`default_nettype none

module nvm_store #(
    parameter EE_AW = 6,
    parameter EE_DW = 8,
    parameter FL_AW = 11,
    parameter FL_DW = 14
) (
    input  wire             clk,
    input  wire             ee_we,
    input  wire [EE_AW-1:0] ee_addr,
    input  wire [EE_DW-1:0] ee_wdata,
    output wire [EE_DW-1:0] ee_rdata,
    input  wire             fl_we,
    input  wire [FL_AW-1:0] fl_addr,
    input  wire [FL_DW-1:0] fl_wdata,
    output wire [FL_DW-1:0] fl_rdata
);

    // No reset: contents survive every reset, as nonvolatile cells would
    reg [EE_DW-1:0] ee_mem [0:(1<<EE_AW)-1];
    reg [FL_DW-1:0] fl_mem [0:(1<<FL_AW)-1];

    assign ee_rdata = ee_mem[ee_addr];
    assign fl_rdata = fl_mem[fl_addr];

    always @(posedge clk) begin
        if (ee_we) begin
            ee_mem[ee_addr] <= ee_wdata;
        end
        if (fl_we) begin
            fl_mem[fl_addr] <= fl_wdata;
        end
    end

endmodule

`default_nettype wire

// *** rtl/nvm_data_program_access.v ***
// Register-controlled read and timed write access to data and program memory
`default_nettype none
`include "nvm_consts.vh"

module nvm_data_program_access #(
    parameter ERASE_CYCLES = `NVM_ERASE_CYC,
    parameter PROG_CYCLES  = `NVM_PROG_CYC,
    parameter CNT_W        = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        external_pin_reset,
    input  wire        watchdog_reset,
    output wire        core_stall,
    output wire        irq_hold,
    output wire        nvm_done
);

    // ----------------------------------------------------------------
    // Local constants
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_SETUP = 4'h2;
    localparam [3:0] S_ERASE = 4'h4;
    localparam [3:0] S_PROG  = 4'h8;

    localparam [CNT_W-1:0] ERASE_LOAD = ERASE_CYCLES - 1;
    localparam [CNT_W-1:0] PROG_LOAD  = PROG_CYCLES - 1;
    localparam [CNT_W-1:0] SETUP_LOAD = `NVM_SETUP_SLOTS - 1;
    localparam [1:0]       FRD_LOAD   = `NVM_FLASH_RD_SLOTS - 1;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [31:0]      prdata_reg;
    reg              pready_reg;
    reg              pslverr_reg;
    reg              stall_reg;
    reg              hold_reg;
    reg  [1:0]       xrst_sync_reg;
    reg  [1:0]       wdt_sync_reg;
    reg              space_reg;
    reg              abort_reg;
    reg              modify_permit_reg;
    reg              wr_reg;
    reg              rd_reg;
    reg              done_reg;
    reg  [1:0]       rd_cnt_reg;
    reg  [1:0]       unlock_reg;
    reg  [1:0]       unlock_next;
    reg  [7:0]       low_reg;
    reg  [5:0]       high_reg;
    reg  [7:0]       idx_lo_reg;
    reg  [7:0]       idx_hi_reg;
    reg  [12:0]      acc_addr_reg;
    reg  [13:0]      acc_data_reg;
    reg              acc_space_reg;
    reg  [3:0]       state_reg;
    reg  [3:0]       state_next;
    reg  [CNT_W-1:0] cnt_reg;
    reg  [CNT_W-1:0] cnt_next;
    reg  [31:0]      rdata_next;

    wire             soft_rst;
    wire             setup;
    wire             wr_acc;
    wire             hit_ctl;
    wire             hit_key;
    wire             hit_lo;
    wire             hit_hi;
    wire             hit_il;
    wire             hit_ih;
    wire             hit_st;
    wire             mapped;
    wire             busy;
    wire             ctl_wr;
    wire             key_wr;
    wire             space_eff;
    wire             launch;
    wire             fetch;
    wire             rd_done;
    wire             erase_end;
    wire             prog_end;
    wire             stall_next;
    wire [7:0]       ee_rdata;
    wire [13:0]      fl_rdata;
    wire             ee_we;
    wire             fl_we;
    wire [13:0]      mem_wdata;

    // ----------------------------------------------------------------
    // Output drive
    // ----------------------------------------------------------------
    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign core_stall = stall_reg;
    assign irq_hold   = hold_reg;
    assign nvm_done   = done_reg;

    // ----------------------------------------------------------------
    // Soft reset synchronisers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xrst_sync_reg <= 2'b00;
            wdt_sync_reg  <= 2'b00;
        end else begin
            xrst_sync_reg <= {xrst_sync_reg[0], external_pin_reset};
            wdt_sync_reg  <= {wdt_sync_reg[0], watchdog_reset};
        end
    end

    assign soft_rst = xrst_sync_reg[1] | wdt_sync_reg[1];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pready_reg & pwrite;
    assign hit_ctl = (paddr == `NVM_CTL_OFS);
    assign hit_key = (paddr == `NVM_KEY_OFS);
    assign hit_lo  = (paddr == `NVM_LO_OFS);
    assign hit_hi  = (paddr == `NVM_HI_OFS);
    assign hit_il  = (paddr == `NVM_IL_OFS);
    assign hit_ih  = (paddr == `NVM_IH_OFS);
    assign hit_st  = (paddr == `NVM_ST_OFS);
    assign mapped  = hit_ctl | hit_key | hit_lo | hit_hi | hit_il | hit_ih | hit_st;
    assign ctl_wr  = wr_acc & hit_ctl;
    assign key_wr  = wr_acc & hit_key;
    assign busy    = rd_reg | wr_reg;

    // Selection frozen while an access runs
    assign space_eff = (ctl_wr & ~busy) ? pwdata[`NVM_SPACE_BIT] : space_reg;

    // Old permit value only, so permit and launch in one write fail
    assign launch = ctl_wr & pwdata[`NVM_WR_BIT] & modify_permit_reg
                  & (unlock_reg == 2'd2) & ~busy & ~soft_rst;
    assign fetch  = ctl_wr & pwdata[`NVM_RD_BIT] & ~busy & ~launch & ~soft_rst;

    // Only single-location writes exist; no path erases a whole array
    assign rd_done   = rd_reg & (rd_cnt_reg == 2'd0) & ~soft_rst;
    assign erase_end = state_reg[2] & (cnt_reg == {CNT_W{1'b0}}) & ~soft_rst;
    assign prog_end  = state_reg[3] & (cnt_reg == {CNT_W{1'b0}}) & ~soft_rst;

    // ----------------------------------------------------------------
    // Read data mux
    // ----------------------------------------------------------------
    always @* begin
        rdata_next = 32'h0000_0000;
        if (hit_ctl) begin
            rdata_next[`NVM_SPACE_BIT] = space_reg;
            rdata_next[`NVM_ERR_BIT]   = abort_reg;
            rdata_next[`NVM_MODIFY_PERMIT_BIT]  = modify_permit_reg;
            rdata_next[`NVM_WR_BIT]    = wr_reg;
            rdata_next[`NVM_RD_BIT]    = rd_reg;
        end else if (hit_lo) begin
            rdata_next[7:0] = low_reg;
        end else if (hit_hi) begin
            rdata_next[5:0] = high_reg;
        end else if (hit_il) begin
            rdata_next[7:0] = idx_lo_reg;
        end else if (hit_ih) begin
            rdata_next[7:0] = idx_hi_reg;
        end else if (hit_st) begin
            rdata_next[`NVM_DONE_BIT] = done_reg;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: no wait state, answer prepared in the setup cycle
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup) begin
                prdata_reg <= rdata_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // Unlock sequence detector
    // ----------------------------------------------------------------
    // Any other write in between breaks the sequence; nothing is stored
    always @* begin
        unlock_next = unlock_reg;
        if (soft_rst) begin
            unlock_next = 2'd0;
        end else if (wr_acc) begin
            if (key_wr && pwdata[7:0] == `NVM_KEY_FIRST) begin
                unlock_next = 2'd1;
            end else if (key_wr && pwdata[7:0] == `NVM_KEY_SECOND && unlock_reg == 2'd1) begin
                unlock_next = 2'd2;
            end else begin
                unlock_next = 2'd0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Write cycle sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            S_IDLE: begin
                if (launch) begin
                    if (space_eff) begin
                        state_next = S_SETUP;
                        cnt_next   = SETUP_LOAD;
                    end else begin
                        state_next = S_ERASE;
                        cnt_next   = ERASE_LOAD;
                    end
                end
            end
            S_SETUP: begin
                if (cnt_reg == {CNT_W{1'b0}}) begin
                    state_next = S_ERASE;
                    cnt_next   = ERASE_LOAD;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            S_ERASE: begin
                if (cnt_reg == {CNT_W{1'b0}}) begin
                    state_next = S_PROG;
                    cnt_next   = PROG_LOAD;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            S_PROG: begin
                if (cnt_reg == {CNT_W{1'b0}}) begin
                    state_next = S_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = S_IDLE;
                cnt_next   = {CNT_W{1'b0}};
            end
        endcase
        if (soft_rst) begin
            state_next = S_IDLE;
            cnt_next   = {CNT_W{1'b0}};
        end
    end

    // Core halts only for program memory erase and program phases
    assign stall_next = (state_next[2] | state_next[3])
                      & (state_reg[0] ? space_eff : acc_space_reg);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= S_IDLE;
            cnt_reg    <= {CNT_W{1'b0}};
            unlock_reg <= 2'd0;
            stall_reg  <= 1'b0;
            hold_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            unlock_reg <= unlock_next;
            stall_reg  <= stall_next;
            // Held one cycle past release so the next instruction runs first
            hold_reg   <= stall_next | stall_reg;
        end
    end

    // ----------------------------------------------------------------
    // Control and status bits
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            space_reg  <= `NVM_CTL_RST;
            abort_reg  <= `NVM_CTL_RST;
            modify_permit_reg   <= `NVM_CTL_RST;
            wr_reg     <= `NVM_CTL_RST;
            rd_reg     <= `NVM_CTL_RST;
            done_reg   <= `NVM_CTL_RST;
            rd_cnt_reg <= 2'd0;
        end else begin
            if (ctl_wr && !busy) begin
                space_reg <= pwdata[`NVM_SPACE_BIT];
            end
            // Set by an interrupted write wins over a software clear
            if (soft_rst && wr_reg) begin
                abort_reg <= 1'b1;
            end else if (ctl_wr) begin
                abort_reg <= pwdata[`NVM_ERR_BIT];
            end
            // Permit is free to change mid-write; the cycle runs on
            if (soft_rst) begin
                modify_permit_reg <= 1'b0;
            end else if (ctl_wr) begin
                modify_permit_reg <= pwdata[`NVM_MODIFY_PERMIT_BIT];
            end
            // Software can only set; hardware clears at the end
            if (soft_rst || prog_end) begin
                wr_reg <= 1'b0;
            end else if (launch) begin
                wr_reg <= 1'b1;
            end
            if (soft_rst || rd_done) begin
                rd_reg <= 1'b0;
            end else if (fetch) begin
                rd_reg     <= 1'b1;
                rd_cnt_reg <= space_eff ? FRD_LOAD : 2'd0;
            end
            if (rd_reg && rd_cnt_reg != 2'd0) begin
                rd_cnt_reg <= rd_cnt_reg - 2'd1;
            end
            // Completion wins over a software clear in the same cycle
            if (prog_end) begin
                done_reg <= 1'b1;
            end else if (wr_acc && hit_st) begin
                done_reg <= pwdata[`NVM_DONE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Data and index registers
    // ----------------------------------------------------------------
    // Only power-on clears these; pin and watchdog resets leave them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_reg    <= 8'h00;
            high_reg   <= 6'h00;
            idx_lo_reg <= 8'h00;
            idx_hi_reg <= 8'h00;
        end else begin
            if (rd_done) begin
                if (acc_space_reg) begin
                    low_reg  <= fl_rdata[7:0];
                    high_reg <= fl_rdata[13:8];
                end else begin
                    low_reg <= ee_rdata;
                end
            end else begin
                if (wr_acc && hit_lo) begin
                    low_reg <= pwdata[7:0];
                end
                if (wr_acc && hit_hi) begin
                    high_reg <= pwdata[5:0];
                end
            end
            if (wr_acc && hit_il) begin
                idx_lo_reg <= pwdata[7:0];
            end
            if (wr_acc && hit_ih) begin
                idx_hi_reg <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Access snapshot
    // ----------------------------------------------------------------
    // Latched at start so later register writes cannot corrupt a cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_addr_reg  <= 13'h0000;
            acc_data_reg  <= 14'h0000;
            acc_space_reg <= 1'b0;
        end else if (launch || fetch) begin
            acc_addr_reg  <= space_eff ? {idx_hi_reg[4:0], idx_lo_reg}
                                       : {5'h00, idx_lo_reg};
            acc_data_reg  <= space_eff ? {high_reg, low_reg} : {6'h00, low_reg};
            acc_space_reg <= space_eff;
        end
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Erase leaves all ones, then the program phase stores the value
    assign mem_wdata = prog_end ? acc_data_reg : 14'h3FFF;
    assign ee_we     = (erase_end | prog_end) & ~acc_space_reg;
    assign fl_we     = (erase_end | prog_end) & acc_space_reg;

    // Upper index bits beyond the array are ignored by the storage
    nvm_store #(
        .EE_AW (6),
        .EE_DW (8),
        .FL_AW (11),
        .FL_DW (14)
    ) u_store (
        .clk      (pclk),
        .ee_we    (ee_we),
        .ee_addr  (acc_addr_reg[5:0]),
        .ee_wdata (mem_wdata[7:0]),
        .ee_rdata (ee_rdata),
        .fl_we    (fl_we),
        .fl_addr  (acc_addr_reg[10:0]),
        .fl_wdata (mem_wdata),
        .fl_rdata (fl_rdata)
    );

endmodule

`default_nettype wire

// *** dv/nvm_access_chk.sv ***
// Concurrent checks on the nonvolatile access block ports
`default_nettype none
module nvm_access_chk #(
    parameter ERASE_CYCLES = 4,
    parameter PROG_CYCLES  = 4,
    parameter CNT_W        = 16
) (
    input wire        pclk,
    input wire        presetn,
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        external_pin_reset,
    input wire        watchdog_reset,
    input wire        core_stall,
    input wire        irq_hold,
    input wire        nvm_done
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [CNT_W-1:0] cnt_reg;
    reg  [3:0]       soft_reg;
    // A soft reset cuts a stall short, so length checks skip that window
    wire             calm = !(|soft_reg) && !external_pin_reset && !watchdog_reset;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= '0;
            soft_reg <= 4'h0;
        end else begin
            cnt_reg  <= core_stall ? cnt_reg + 1'b1 : '0;
            soft_reg <= {soft_reg[2:0], external_pin_reset | watchdog_reset};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_stall_length: assert property ($fell(core_stall) && calm |-> cnt_reg == ERASE_CYCLES + PROG_CYCLES)
        else $error("stall length wrong");
    a_stall_done: assert property ($fell(core_stall) && calm |-> nvm_done)
        else $error("done missing at stall end");
    a_hold_during: assert property (core_stall |-> irq_hold)
        else $error("events not held in stall");
    a_hold_tail: assert property ($fell(core_stall) |-> irq_hold ##1 !irq_hold)
        else $error("hold tail wrong");
    // Launch edge, two setup slots, then the stall is first seen high one edge later
    a_stall_cause: assert property ($rose(core_stall) |->
        $past(psel && penable && pready && pwrite && paddr == 12'h18C && pwdata[1], 3))
        else $error("stall without launch three edges before");
    a_soft_abort: assert property ((external_pin_reset || watchdog_reset) [*4] |=> !core_stall)
        else $error("soft reset left write running");
    a_high_zero: assert property (psel && penable && !pwrite && pready && paddr == 12'h198
        |-> prdata[31:6] == 26'h0)
        else $error("high byte upper bits set");
    a_done_hold: assert property (nvm_done && !(psel && pwrite && paddr == 12'h1A4) |=> nvm_done)
        else $error("done flag lost");
endmodule
bind nvm_data_program_access nvm_access_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES),
    .CNT_W(CNT_W)) i_nvm_access_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .external_pin_reset(external_pin_reset), .watchdog_reset(watchdog_reset),
    .core_stall(core_stall), .irq_hold(irq_hold), .nvm_done(nvm_done));
`default_nettype wire

// *** dv/test_nvm_data_program_access.sv ***
// Self-checking bench for the nonvolatile access block
`default_nettype none
`include "nvm_consts.vh"
module test_nvm_data_program_access;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        external_pin_reset = 1'b0;
    logic        watchdog_reset = 1'b0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         core_stall;
    wire         irq_hold;
    wire         nvm_done;
    logic [31:0] rd;
    logic [31:0] lf = 32'h00013080;
    logic        er;
    logic [7:0]  bp [3] = '{8'h00, 8'h04, 8'h04};
    logic [7:0]  bk [3] = '{8'h55, 8'hAA, 8'h00};
    int          mismatches = 0;
    int          comparisons = 0;
    nvm_data_program_access #(.ERASE_CYCLES(4), .PROG_CYCLES(4), .CNT_W(16)) i_nvm_data_program_access (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_pin_reset(external_pin_reset), .watchdog_reset(watchdog_reset),
        .core_stall(core_stall), .irq_hold(irq_hold), .nvm_done(nvm_done));
    initial forever #5 pclk = ~pclk;
    function logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task wrap_up;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Request stands until pready is seen high at a rising edge; the answer is taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task launch(input logic sp, input logic [10:0] a, input logic [13:0] d, input logic [7:0] pre, k1, k2);
        apb(1'b1, `NVM_LO_OFS, {24'h0, d[7:0]});
        apb(1'b1, `NVM_HI_OFS, {26'h0, d[13:8]});
        apb(1'b1, `NVM_IL_OFS, {24'h0, a[7:0]});
        apb(1'b1, `NVM_IH_OFS, {29'h0, a[10:8]});
        apb(1'b1, `NVM_CTL_OFS, {24'h0, sp, pre[6:0]});
        apb(1'b1, `NVM_KEY_OFS, {24'h0, k1});
        apb(1'b1, `NVM_KEY_OFS, {24'h0, k2});
        apb(1'b1, `NVM_CTL_OFS, {24'h0, sp, 7'h06});
    endtask
    task good(input logic sp, input logic [10:0] a, input logic [13:0] d);
        launch(sp, a, d, 8'h04, 8'h55, 8'hAA);
        // Flip space and drop permit mid-write: the flip is ignored, the permit clears and the write still completes
        apb(1'b1, `NVM_CTL_OFS, {24'h0, ~sp, 7'h00});
        @(negedge pclk);
        chk({31'h0, core_stall}, {31'h0, sp});
        do apb(1'b0, `NVM_CTL_OFS, 32'h0); while (rd[1] === 1'b1);
        chk({31'h0, nvm_done}, 32'h1);
        rdc(`NVM_ST_OFS, 32'h1);
        apb(1'b1, `NVM_ST_OFS, 32'h0);
        apb(1'b1, `NVM_LO_OFS, 32'h0);
        apb(1'b1, `NVM_HI_OFS, 32'hFF);
        apb(1'b1, `NVM_CTL_OFS, {24'h0, sp, 7'h01});
        // A program read still runs at the next setup edge, so let it finish first
        @(posedge pclk);
        rdc(`NVM_CTL_OFS, {24'h0, sp, 7'h00});
        rdc(`NVM_LO_OFS, {24'h0, d[7:0]});
        rdc(`NVM_HI_OFS, sp ? {26'h0, d[13:8]} : 32'h3F);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`NVM_CTL_OFS, 32'h0);
        rdc(`NVM_ST_OFS, 32'h0);
        apb(1'b1, 12'h000, 32'hFF);
        rdc(12'h000, 32'h0);
        chk({31'h0, er}, 32'h1);
        good(1'b0, 11'h03F, 14'h00FF);
        good(1'b1, 11'h7FF, 14'h3FFF);
        for (int i = 0; i < 6; i++) begin
            lf = nx(lf);
            good(i[0], lf[10:0] & (i[0] ? 11'h7FF : 11'h03F), lf[24:11]);
        end
        for (int j = 0; j < 3; j++) begin
            // No permit beforehand, then a wrong first key, then a missing first key
            launch(1'b0, 11'h011, 14'h0042, bp[j], bk[j], 8'hAA);
            repeat (12) @(posedge pclk);
            rdc(`NVM_ST_OFS, 32'h0);
            rdc(`NVM_CTL_OFS, 32'h4);
        end
        for (int i = 0; i < 2; i++) begin
            launch(i[0], 11'h02A, 14'h15A5, 8'h04, 8'h55, 8'hAA);
            if (i == 0)
                external_pin_reset <= 1'b1;
            else
                watchdog_reset <= 1'b1;
            repeat (4) @(posedge pclk);
            external_pin_reset <= 1'b0;
            watchdog_reset <= 1'b0;
            repeat (3) @(posedge pclk);
            rdc(`NVM_CTL_OFS, {24'h0, i[0], 7'h08});
            rdc(`NVM_LO_OFS, 32'hA5);
            rdc(`NVM_IL_OFS, 32'h2A);
            apb(1'b1, `NVM_CTL_OFS, 32'h0);
        end
        wrap_up;
    end
    initial begin
        #300000;
        mismatches++;
        wrap_up;
    end
endmodule
`default_nettype wire
